/* common/sspi_pkg.sv */
`default_nettype none
package sspi_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_FLAGS = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   // ==========================================================
   // module_control_register fields
   localparam int unsigned CTRL_MODE_LSB = 5;
   localparam int unsigned CTRL_EN = 1;
   localparam int unsigned CTRL_ICF = 0;
   localparam logic [7:0] CTRL_RST = 8'hE0;
   localparam logic [7:0] CTRL_MASK = 8'hEF;
   // ==========================================================
   // spi_control_flags fields
   localparam int unsigned FL_POL = 5;
   localparam int unsigned FL_EDGE = 4;
   localparam int unsigned FL_ORDER = 3;
   localparam int unsigned FL_SELECT_PIN_ENABLE = 2;
   localparam int unsigned FL_WRITE_COLLISION_FLAG = 1;
   localparam int unsigned FL_TRF = 0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   // ==========================================================
   // function_mode_field values
   localparam logic [2:0] MODE_DIV4 = 3'h0;
   localparam logic [2:0] MODE_DIV16 = 3'h1;
   localparam logic [2:0] MODE_DIV64 = 3'h2;
   localparam logic [2:0] MODE_SUB = 3'h3;
   localparam logic [2:0] MODE_TIMER = 3'h4;
   localparam logic [2:0] MODE_SLAVE = 3'h5;
   // ==========================================================
   // Timing: half of the serial clock period in mclk cycles
   localparam logic [5:0] HALF_DIV4 = 6'h02;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hF;
endpackage : sspi_pkg
`default_nettype wire

/* common/sspi_shift_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sspi_shift_if;
   logic load;
   logic [7:0] loadData;
   logic shift;
   logic inBit;
   logic msbFirst;
   logic [7:0] data;
   logic outBit;
   modport ctrl (output load, loadData, shift, inBit, msbFirst, input data, outBit);
   modport sreg (input load, loadData, shift, inBit, msbFirst, output data, outBit);
endinterface : sspi_shift_if
`default_nettype wire

/* src/sspi_clk_div.sv */
`timescale 1ns/1ns
`default_nettype none
module sspi_clk_div (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] mode,
   input wire logic run,
   input wire logic subClk,
   input wire logic timerMatch,
   output logic halfTick
);
   logic [5:0] cnt;
   logic [5:0] next_cnt;
   logic subPrev;
   logic next_tick;

   function automatic logic [5:0] halfCount(input logic [2:0] m);
      case (m)
         sspi_pkg::MODE_DIV4: halfCount = sspi_pkg::HALF_DIV4;
         sspi_pkg::MODE_DIV16: halfCount = sspi_pkg::HALF_DIV16;
         default: halfCount = sspi_pkg::HALF_DIV64;
      endcase
   endfunction : halfCount

   always_comb begin
      next_cnt = 6'h00;
      next_tick = 1'b0;
      if (run) begin
         case (mode)
            // Sub clock: every level change is half a serial period
            sspi_pkg::MODE_SUB: next_tick = subClk ^ subPrev;
            // Each timer match is half a serial period
            sspi_pkg::MODE_TIMER: next_tick = timerMatch;
            default: begin
               next_tick = (cnt == halfCount(mode) - 6'h01);
               next_cnt = next_tick ? 6'h00 : cnt + 6'h01;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 6'h00;
         subPrev <= 1'b0;
         halfTick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         subPrev <= subClk;
         halfTick <= next_tick;
      end
   end
endmodule : sspi_clk_div
`default_nettype wire

/* src/sspi_shifter.sv */
`timescale 1ns/1ns
`default_nettype none
module sspi_shifter (
   input wire logic mclk,
   input wire logic rst_n,
   sspi_shift_if.sreg sh
);
   logic [7:0] next_data;

   always_comb begin
      next_data = sh.data;
      if (sh.load) begin
         next_data = sh.loadData;
      end else if (sh.shift) begin
         next_data = sh.msbFirst ? {sh.data[6:0], sh.inBit} : {sh.inBit, sh.data[7:1]};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sh.data <= 8'h00;
      end else begin
         sh.data <= next_data;
      end
   end

   assign sh.outBit = sh.msbFirst ? sh.data[7] : sh.data[0];
endmodule : sspi_shifter
`default_nettype wire

/* src/sspi_top.sv */
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Polarity 0 idles the serial clock high, 1 idles it low.
// - Capture edge follows polarity and edge bits as tabled.
// - Order bit 1 shifts MSB first, 0 LSB first.
// - Select-enable 0 releases the select pin; 1 uses it as select.
// - Data write during a transfer is dropped and sets collision flag.
// - Collision flag stays set until software clears it.
// - Done flag set at transfer end, zero while busy, software cleared.
// - Bits 7:6 of the flags register are plain storage; reset zero.
// - Master: data write starts a full-duplex transfer at once.
// - Slave: external clocks shift data out and serial input in.
// - Slave first bit valid per polarity and edge before first capture.
// - Logic keeps running in processor idle mode.
// - Slave output floats while deselected; first bit follows data write.
// - Slave with select disabled always answers the clock.
// - Mode field picks master clock source, slave, or off.
// - Enable 0 drops pin function; settings are kept.
// - Early deselect sets incomplete and done flags.
module sspi_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [31:0] avWriteData,
   output logic [31:0] avReadData,
   output logic avWaitRequest,
   input wire logic sckIn,
   input wire logic serialInPin,
   input wire logic slaveSelectN,
   input wire logic subClk,
   input wire logic timerMatch,
   output logic sckOut,
   output logic sckOe,
   output logic serialOutPin,
   output logic serialOutOe,
   output logic selectPinActive
);
   typedef enum logic [1:0] {ST_IDLE, ST_MRUN, ST_SRUN} sspi_state_e;

   sspi_shift_if sh ();
   sspi_state_e state;
   sspi_state_e next_state;
   logic [7:0] ctrl;
   logic [7:0] flags;
   logic [7:0] next_ctrl;
   logic [7:0] next_flags;
   logic [31:0] next_avReadData;
   logic next_avWaitRequest;
   logic [3:0] edgeCnt;
   logic [3:0] next_edgeCnt;
   logic [2:0] bitCnt;
   logic [2:0] next_bitCnt;
   logic next_sckOut;
   logic next_sckOe;
   logic next_serialOutPin;
   logic next_serialOutOe;
   logic next_selectPinActive;
   logic sckPrev;
   logic halfTick;
   logic wrAcc;
   logic dataLoad;
   logic dataColl;
   logic spiOn;
   logic isMaster;
   logic isSlave;
   logic slaveLive;
   logic sckEdge;
   logic sCap;
   logic mCap;
   logic startEv;
   logic doneEv;
   logic icfEv;
   logic [2:0] mode;
   logic pol;
   logic clock_capture_edge;
   logic order;
   logic select_pin_enable;

   function automatic logic firstBit(input logic [7:0] d, input logic msb);
      firstBit = msb ? d[7] : d[0];
   endfunction : firstBit

   // ==========================================================
   // Configuration decode
   assign mode = ctrl[sspi_pkg::CTRL_MODE_LSB +: 3];
   assign pol = flags[sspi_pkg::FL_POL];
   assign clock_capture_edge = flags[sspi_pkg::FL_EDGE];
   assign order = flags[sspi_pkg::FL_ORDER];
   assign select_pin_enable = flags[sspi_pkg::FL_SELECT_PIN_ENABLE];
   assign isMaster = (mode <= sspi_pkg::MODE_TIMER);
   assign isSlave = (mode == sspi_pkg::MODE_SLAVE);
   // I2C and off codes leave the SPI idle; settings stay put
   assign spiOn = ctrl[sspi_pkg::CTRL_EN] && (isMaster || isSlave);
   assign slaveLive = spiOn && isSlave && (!select_pin_enable || !slaveSelectN);

   // ==========================================================
   // Avalon slave: one wait cycle, then the access completes
   assign wrAcc = avWrite && !avWaitRequest;
   assign dataLoad = wrAcc && avAddress == sspi_pkg::OFS_DATA && state == ST_IDLE;
   assign dataColl = wrAcc && avAddress == sspi_pkg::OFS_DATA && state != ST_IDLE;

   always_comb begin
      next_avWaitRequest = !((avRead || avWrite) && avWaitRequest);
      next_avReadData = avReadData;
      if ((avRead || avWrite) && avWaitRequest) begin
         case (avAddress)
            sspi_pkg::OFS_CTRL: next_avReadData = {24'h000000, ctrl};
            sspi_pkg::OFS_FLAGS: next_avReadData = {24'h000000, flags};
            sspi_pkg::OFS_DATA: next_avReadData = {24'h000000, sh.data};
            default: next_avReadData = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avWaitRequest <= 1'b1;
         avReadData <= 32'h00000000;
      end else begin
         avWaitRequest <= next_avWaitRequest;
         avReadData <= next_avReadData;
      end
   end

   // ==========================================================
   // Control and flag registers; hardware sets win over writes
   always_comb begin
      next_ctrl = ctrl;
      next_flags = flags;
      if (wrAcc && avAddress == sspi_pkg::OFS_CTRL) begin
         next_ctrl = avWriteData[7:0] & sspi_pkg::CTRL_MASK;
      end
      if (wrAcc && avAddress == sspi_pkg::OFS_FLAGS) begin
         next_flags = avWriteData[7:0];
      end
      if (dataColl) begin
         next_flags[sspi_pkg::FL_WRITE_COLLISION_FLAG] = 1'b1;
      end
      if (startEv) begin
         next_flags[sspi_pkg::FL_TRF] = 1'b0;
      end
      if (doneEv) begin
         next_flags[sspi_pkg::FL_TRF] = 1'b1;
      end
      if (icfEv) begin
         next_ctrl[sspi_pkg::CTRL_ICF] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= sspi_pkg::CTRL_RST;
         flags <= sspi_pkg::FLAGS_RST;
      end else begin
         ctrl <= next_ctrl;
         flags <= next_flags;
      end
   end

   // ==========================================================
   // Transfer engine
   // Edge bit 1 captures on the leading edge in both polarities
   assign sckEdge = sckIn ^ sckPrev;
   assign sCap = (sckPrev == ~pol) == clock_capture_edge;
   assign mCap = (~edgeCnt[0]) == clock_capture_edge;

   assign sh.load = dataLoad;
   assign sh.loadData = avWriteData[7:0];
   assign sh.inBit = serialInPin;
   assign sh.msbFirst = order;

   always_comb begin
      next_state = state;
      next_edgeCnt = edgeCnt;
      next_bitCnt = bitCnt;
      next_sckOut = sckOut;
      next_serialOutPin = serialOutPin;
      sh.shift = 1'b0;
      startEv = 1'b0;
      doneEv = 1'b0;
      icfEv = 1'b0;
      case (state)
         ST_MRUN: begin
            if (!spiOn || !isMaster) begin
               next_state = ST_IDLE;
            end else if (halfTick) begin
               next_sckOut = ~sckOut;
               next_edgeCnt = edgeCnt + 4'h1;
               if (mCap) begin
                  sh.shift = 1'b1;
               end else begin
                  next_serialOutPin = sh.outBit;
               end
               // Sixteen edges leave the clock at its idle level
               if (edgeCnt == sspi_pkg::LAST_EDGE) begin
                  doneEv = 1'b1;
                  next_state = ST_IDLE;
               end
            end
         end
         ST_IDLE, ST_SRUN: begin
            if (state == ST_IDLE) begin
               next_sckOut = ~pol;
               next_edgeCnt = 4'h0;
            end
            if (dataLoad) begin
               // Output follows the write before any clock arrives
               next_serialOutPin = firstBit(avWriteData[7:0], order);
               if (spiOn && isMaster) begin
                  startEv = 1'b1;
                  next_state = ST_MRUN;
               end
            end else if (slaveLive && sckEdge) begin
               if (sCap) begin
                  sh.shift = 1'b1;
                  startEv = (bitCnt == 3'h0);
                  next_bitCnt = bitCnt + 3'h1;
                  next_state = ST_SRUN;
                  if (bitCnt == sspi_pkg::LAST_BIT) begin
                     startEv = 1'b0;
                     doneEv = 1'b1;
                     next_state = ST_IDLE;
                  end
               end else begin
                  next_serialOutPin = sh.outBit;
               end
            end else if (state == ST_SRUN && !slaveLive) begin
               next_bitCnt = 3'h0;
               next_state = ST_IDLE;
               if (spiOn && isSlave && select_pin_enable && slaveSelectN) begin
                  icfEv = 1'b1;
                  doneEv = 1'b1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Pins lose their function once disabled
   always_comb begin
      next_sckOe = spiOn && isMaster;
      next_serialOutOe = spiOn && (isMaster || slaveLive);
      next_selectPinActive = spiOn && isSlave && select_pin_enable;
   end

   // No gating on any low-power state: the engine runs on mclk alone
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         edgeCnt <= 4'h0;
         bitCnt <= 3'h0;
         sckOut <= 1'b1;
         serialOutPin <= 1'b0;
         sckPrev <= 1'b1;
         sckOe <= 1'b0;
         serialOutOe <= 1'b0;
         selectPinActive <= 1'b0;
      end else begin
         state <= next_state;
         edgeCnt <= next_edgeCnt;
         bitCnt <= next_bitCnt;
         sckOut <= next_sckOut;
         serialOutPin <= next_serialOutPin;
         sckPrev <= sckIn;
         sckOe <= next_sckOe;
         serialOutOe <= next_serialOutOe;
         selectPinActive <= next_selectPinActive;
      end
   end

   sspi_clk_div u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .mode(mode),
      .run(state == ST_MRUN),
      .subClk(subClk),
      .timerMatch(timerMatch),
      .halfTick(halfTick)
   );

   sspi_shifter u_shift (
      .mclk(mclk),
      .rst_n(rst_n),
      .sh(sh)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   idle_clock_level_a: assert property (
      state == ST_IDLE |=> sckOut == !$past(pol)) else $error("clock not at idle level");
   collision_set_a: assert property (
      dataColl |=> flags[sspi_pkg::FL_WRITE_COLLISION_FLAG] && state != ST_IDLE) else $error("collision lost");
   collision_sticky_a: assert property (
      flags[sspi_pkg::FL_WRITE_COLLISION_FLAG] && !(wrAcc && avAddress == sspi_pkg::OFS_FLAGS)
      |=> flags[sspi_pkg::FL_WRITE_COLLISION_FLAG]) else $error("collision flag cleared by hardware");
   master_start_a: assert property (
      dataLoad && spiOn && isMaster |=> state == ST_MRUN && !flags[sspi_pkg::FL_TRF])
      else $error("master transfer did not start");
   master_end_a: assert property (
      state == ST_MRUN && halfTick && edgeCnt == sspi_pkg::LAST_EDGE && spiOn && isMaster
      |=> state == ST_IDLE && flags[sspi_pkg::FL_TRF] && sckOut == !pol)
      else $error("master end wrong");
   first_bit_a: assert property (
      dataLoad |=> serialOutPin == ($past(order) ? $past(avWriteData[7]) : $past(avWriteData[0])))
      else $error("wrong first bit");
   early_deselect_a: assert property (
      state == ST_SRUN && spiOn && isSlave && select_pin_enable && slaveSelectN && !dataColl
      |=> ctrl[sspi_pkg::CTRL_ICF] && flags[sspi_pkg::FL_TRF] && state == ST_IDLE)
      else $error("early deselect not flagged");
   slave_float_a: assert property (
      isSlave && select_pin_enable && slaveSelectN |=> !serialOutOe) else $error("output not floating");
   select_ignored_a: assert property (
      spiOn && isSlave && !select_pin_enable |=> serialOutOe) else $error("slave not answering");
   disabled_pins_a: assert property (
      !ctrl[sspi_pkg::CTRL_EN] |=> !sckOe && !serialOutOe && !selectPinActive)
      else $error("pins driven while disabled");

   master_done_c: cover property (state == ST_MRUN ##1 state == ST_IDLE);
   slave_done_c: cover property (state == ST_SRUN && doneEv && !icfEv);
   collision_c: cover property (dataColl);
   deselect_c: cover property (icfEv);
endmodule : sspi_top
`default_nettype wire

/* tb/sspi_peer_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Far-side device: slave to our master, master to our slave
module sspi_peer_model (
   input wire logic mclk,
   input wire logic pol,
   input wire logic edg,
   input wire logic msb,
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic serialOutPin,
   output logic sckIn,
   output logic serialInPin,
   output logic slaveSelectN
);
   logic [7:0] tx = 8'h00;
   logic [7:0] rx = 8'h00;
   logic [3:0] cnt = 4'h8;
   logic [2:0] idleCnt = 3'h7;
   logic lastSck = 1'b1;
   logic mact = 1'b0;
   initial begin
      sckIn = 1'b1;
      serialInPin = 1'b0;
      slaveSelectN = 1'b1;
   end
   function automatic logic bitOf(input logic [7:0] v, input int n);
      return msb ? v[7 - n] : v[n];
   endfunction : bitOf
   function automatic logic [7:0] push(input logic [7:0] v, input logic b);
      return msb ? {v[6:0], b} : {b, v[7:1]};
   endfunction : push
   // First bit must stand before the first capture edge
   task automatic arm(input logic [7:0] v);
      tx = v;
      cnt = 4'h0;
      serialInPin <= bitOf(v, 0);
   endtask : arm
   always @(posedge mclk) begin
      if (sckOe === 1'b1 && sckOut !== lastSck && cnt < 4'h8) begin
         if (sckOut == (pol == edg)) begin
            rx <= push(rx, serialOutPin);
            cnt <= cnt + 4'h1;
         end else if (cnt != 4'h0) begin
            serialInPin <= bitOf(tx, 32'(cnt));
         end
      end else if (!mact && idleCnt == 3'h4) begin
         // Hold time over: never leave a stale bit on the line
         serialInPin <= ~serialInPin;
      end
      idleCnt <= (cnt == 4'h8) ? idleCnt + 3'(idleCnt != 3'h7) : 3'h0;
      if (!mact) begin
         sckIn <= !pol;
      end
      lastSck <= sckOut;
   end
   // Master role: select first, then clock; half period of 6 mclk
   task automatic xfer(input logic [7:0] v, input int nb, input logic sel);
      int i;
      int n;
      mact = 1'b1;
      n = 0;
      rx = 8'h00;
      @(posedge mclk);
      slaveSelectN <= ~sel;
      serialInPin <= bitOf(v, 0);
      repeat (6) @(posedge mclk);
      for (i = 0; i < 2 * nb; i++) begin
         if ((i % 2 == 0) == edg) begin
            rx = push(rx, serialOutPin);
            n++;
         end else if (n != 0 && n < nb) begin
            serialInPin <= bitOf(v, n);
         end
         sckIn <= ~sckIn;
         repeat (6) @(posedge mclk);
      end
      slaveSelectN <= 1'b1;
      serialInPin <= ~serialInPin;
      mact = 1'b0;
   endtask : xfer
endmodule : sspi_peer_model
`default_nettype wire

/* tb/test_serial_module_spi_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_serial_module_spi_control;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avAddress = 4'h0;
   logic avRead = 1'b0;
   logic avWrite = 1'b0;
   logic [31:0] avWriteData = 32'h0;
   logic [31:0] avReadData;
   logic avWaitRequest;
   logic sckIn, serialInPin, slaveSelectN, sckOut, sckOe;
   logic serialOutPin, serialOutOe, selectPinActive;
   logic subClk = 1'b0;
   logic timerMatch = 1'b0;
   logic pol = 1'b0;
   logic edg = 1'b0;
   logic msb = 1'b0;
   logic [7:0] rdv;
   logic [63:0] notes[$];
   int badCount = 0;
   int totalChecks = 0;
   int cycles = 0;
   sspi_top uut (.mclk(mclk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
      .avWrite(avWrite), .avWriteData(avWriteData), .avReadData(avReadData),
      .avWaitRequest(avWaitRequest), .sckIn(sckIn), .serialInPin(serialInPin),
      .slaveSelectN(slaveSelectN), .subClk(subClk), .timerMatch(timerMatch),
      .sckOut(sckOut), .sckOe(sckOe), .serialOutPin(serialOutPin),
      .serialOutOe(serialOutOe), .selectPinActive(selectPinActive));
   sspi_peer_model peer (.mclk(mclk), .pol(pol), .edg(edg), .msb(msb), .sckOut(sckOut),
      .sckOe(sckOe), .serialOutPin(serialOutPin), .sckIn(sckIn),
      .serialInPin(serialInPin), .slaveSelectN(slaveSelectN));
   initial begin
      forever #10 mclk = ~mclk;
   end
   // ==========================================
   // Clock sources for sub-clock and timer modes, and hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles % 4 == 0) subClk <= ~subClk;
      timerMatch <= (cycles % 4 == 2);
      if (cycles == 20000) begin
         badCount = badCount + 1;
         endSim();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic endSim();
      if (badCount == 0 && totalChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : endSim
   // ==========================================
   // Read watcher: oldest note against each completed read
   always @(posedge mclk) begin
      logic [63:0] n;
      if (avRead === 1'b1 && avWaitRequest === 1'b0 && notes.size() != 0) begin
         n = notes.pop_front();
         if (n[63:32] != 32'h0) check(avReadData & n[63:32], n[31:0]);
      end
   end
   // ==========================================
   // Avalon master: holds the request until waitrequest is seen low
   task automatic acc(input logic [3:0] a, input logic wr, input logic [7:0] d);
      @(posedge mclk);
      avAddress <= a;
      avWrite <= wr;
      avRead <= ~wr;
      avWriteData <= {24'h0, d};
      @(posedge mclk);
      while (avWaitRequest !== 1'b0) @(posedge mclk);
      rdv = avReadData[7:0];
      avWrite <= 1'b0;
      avRead <= 1'b0;
   endtask : acc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [31:0] m = '1);
      notes.push_back({m, 24'h0, e});
      acc(a, 1'b0, 8'h00);
   endtask : rd
   task automatic waitDone();
      int n;
      n = 0;
      rdv = 8'h00;
      while (rdv[0] !== 1'b1 && n < 400) begin
         rd(sspi_pkg::OFS_FLAGS, 8'h00, 32'h0);
         n++;
      end
   endtask : waitDone
   initial begin
      logic [7:0] cfg, tx, m;
      int k;
      k = $urandom(32'h536F);
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      rd(sspi_pkg::OFS_CTRL, 8'hE0);
      rd(sspi_pkg::OFS_FLAGS, 8'h00);
      rd(sspi_pkg::OFS_DATA, 8'h00);
      rd(4'hC, 8'h00);
      wr(sspi_pkg::OFS_FLAGS, 8'hC0);
      rd(sspi_pkg::OFS_FLAGS, 8'hC0);
      wr(sspi_pkg::OFS_CTRL, 8'hFF);
      rd(sspi_pkg::OFS_CTRL, 8'hEF);
      rd(sspi_pkg::OFS_FLAGS, 8'hC0);
      repeat (2) @(negedge mclk);
      check(sckOe, 1'b0);
      check(serialOutOe, 1'b0);
      // Two-wire slave code must leave the SPI pins alone as well
      wr(sspi_pkg::OFS_CTRL, 8'hC2);
      repeat (2) @(negedge mclk);
      check(sckOe, 1'b0);
      check(serialOutOe, 1'b0);
      // Master: every mode 0..4 and every polarity, edge and order
      for (k = 0; k < 10; k++) begin
         {msb, edg, pol} = k[2:0];
         cfg = {2'b00, pol, edg, msb, 3'b000};
         wr(sspi_pkg::OFS_CTRL, {3'(k % 5), 5'h02});
         wr(sspi_pkg::OFS_FLAGS, cfg);
         repeat (3) @(negedge mclk);
         check(sckOe, 1'b1);
         check(sckOut, !pol);
         tx = 8'($urandom);
         m = 8'($urandom);
         peer.arm(m);
         wr(sspi_pkg::OFS_DATA, tx);
         wr(sspi_pkg::OFS_DATA, ~tx);
         rd(sspi_pkg::OFS_FLAGS, cfg | 8'h02);
         waitDone();
         rd(sspi_pkg::OFS_FLAGS, cfg | 8'h03);
         rd(sspi_pkg::OFS_DATA, m);
         repeat (2) @(negedge mclk);
         check(peer.rx, tx);
         check(sckOut, !pol);
         wr(sspi_pkg::OFS_FLAGS, cfg);
         rd(sspi_pkg::OFS_FLAGS, cfg);
      end
      // Slave with select pin in use
      for (k = 0; k < 8; k++) begin
         {msb, edg, pol} = k[2:0];
         cfg = {2'b00, pol, edg, msb, 3'b100};
         wr(sspi_pkg::OFS_CTRL, 8'hA2);
         wr(sspi_pkg::OFS_FLAGS, cfg);
         repeat (2) @(negedge mclk);
         check(selectPinActive, 1'b1);
         check(serialOutOe, 1'b0);
         tx = 8'($urandom);
         m = 8'($urandom);
         wr(sspi_pkg::OFS_DATA, tx);
         peer.xfer(m, 8, 1'b1);
         rd(sspi_pkg::OFS_FLAGS, cfg | 8'h01);
         rd(sspi_pkg::OFS_DATA, m);
         check(peer.rx, tx);
         wr(sspi_pkg::OFS_FLAGS, cfg);
      end
      wr(sspi_pkg::OFS_CTRL, 8'hA0);
      repeat (2) @(negedge mclk);
      check(selectPinActive, 1'b0);
      wr(sspi_pkg::OFS_CTRL, 8'hA2);
      rd(sspi_pkg::OFS_FLAGS, cfg);
      // Deselect after three bits
      wr(sspi_pkg::OFS_DATA, tx);
      peer.xfer(m, 3, 1'b1);
      rd(sspi_pkg::OFS_CTRL, 8'hA3);
      rd(sspi_pkg::OFS_FLAGS, cfg | 8'h01);
      wr(sspi_pkg::OFS_CTRL, 8'hA2);
      // Select disabled: the slave answers with the select line high
      cfg = cfg & 8'hFB;
      wr(sspi_pkg::OFS_FLAGS, cfg);
      tx = 8'($urandom);
      m = 8'($urandom);
      wr(sspi_pkg::OFS_DATA, tx);
      repeat (2) @(negedge mclk);
      check(selectPinActive, 1'b0);
      check(serialOutOe, 1'b1);
      check(serialOutPin, msb ? tx[7] : tx[0]);
      peer.xfer(m, 8, 1'b0);
      rd(sspi_pkg::OFS_FLAGS, cfg | 8'h01);
      rd(sspi_pkg::OFS_DATA, m);
      check(peer.rx, tx);
      endSim();
   end
endmodule : test_serial_module_spi_control
`default_nettype wire
